// >>> adcc_top.sv
// adcc_top: control of a 10-bit successive-approximation converter.
// assumes a comparator answering dac_code on comp_in, an rc tick pulse
// synchronous to hclk, and a compare unit outside driving the trigger.
//
// Summary of operation
// - conversion takes exactly twelve bit periods
// - bit period from six dividers or rc
// - clock select code table, rc on x11
// - completion loads result, clears go, flags done
// - clearing go aborts conversion at once
// - abort leaves result registers unchanged
// - after abort wait two periods, reacquire
// - trigger in mode 1011 starts conversion
// - trigger also resets first or third timer
// - disabled converter ignores trigger, timer still reset
// - hold capacitor disconnected during the conversion
// - acquisition select adds 0 to 20 periods
// - sequencing ignores channel and direction bits
// - output pins convert their driven level
// - port read gives zero on analog pins
// - resets leave result registers untouched
module adcc_top
  import adcc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic comp_in,
  input wire logic rc_tick,
  input wire logic special_trigger,
  input wire logic [3:0] compare_unit_mode_field,
  input wire logic [15:0] pin_level,
  output adcc_pkg::adcc_ana_type ana,
  output logic timer_reset,
  output logic conv_done_flag,
  output logic [15:0] port_read_value
);
  import adcc_pkg::*;

  // ----------------------------------------
  // decode functions
  // ----------------------------------------
  // oscillator periods per bit period, 0 means rc source
  function automatic logic [6:0] clk_div(input logic [2:0] sel);
    case (sel)
      3'h0: clk_div = 7'd2;
      3'h1: clk_div = 7'd8;
      3'h2: clk_div = 7'd32;
      3'h4: clk_div = 7'd4;
      3'h5: clk_div = 7'd16;
      3'h6: clk_div = 7'd64;
      default: clk_div = 7'd0;
    endcase
  endfunction

  // automatic acquisition length in bit periods
  function automatic logic [4:0] acq_len(input logic [2:0] sel);
    case (sel)
      3'h5: acq_len = 5'd12;
      3'h6: acq_len = 5'd16;
      3'h7: acq_len = 5'd20;
      default: acq_len = {1'b0, sel, 1'b0};
    endcase
  endfunction

  // ----------------------------------------
  // registers and state
  // ----------------------------------------
  logic [7:0] ctl0; // channel, go, on
  logic [7:0] ctl1; // vref and pin configuration
  logic [7:0] ctl2; // format, acquisition, clock
  logic [7:0] res_hi; // no reset on purpose
  logic [7:0] res_lo;
  adcc_bus_type dph; // transfer in data phase
  adcc_state_type state;
  logic [4:0] cnt; // bit periods within a state
  logic [5:0] pre; // prescaler
  logic [ADCC_RES_W-1:0] sar;
  logic bit_tick; // one pulse per bit period
  logic [6:0] div;
  logic go;
  logic conv_on;
  logic wr_ctl0;
  logic conv_done;
  logic trig_hit;
  logic [15:0] amask; // analog pins
  logic [4:0] nana;

  assign go = ctl0[ADCC_GO_BIT];
  assign conv_on = ctl0[ADCC_ON_BIT];
  assign div = clk_div(ctl2[ADCC_CLK_LSB +: 3]);
  assign wr_ctl0 = dph.act && dph.wr && dph.addr == ADCC_OFS_CTL0;
  assign trig_hit = special_trigger && compare_unit_mode_field == ADCC_TRIG_MODE;
  assign conv_done = state == ADCC_CONV && go && bit_tick
    && cnt == ADCC_CONV_TADS - 5'd1;

  // ----------------------------------------
  // ahb-lite slave
  // ----------------------------------------
  // address phase capture; every transfer answers with no wait state
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dph <= '0;
    end
    else if (hready)
    begin
      // only whole words are mapped; hsize is taken as a word
      dph.act <= hsel && htrans[1];
      dph.wr <= hwrite;
      dph.addr <= haddr[7:0];
    end
  end

  // read data registered at the address edge, stands in the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata <= '0;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (hready && hsel && htrans[1] && !hwrite)
      begin
        case (haddr[7:0])
          ADCC_OFS_RES_HI: hrdata <= {24'h000000, res_hi};
          ADCC_OFS_RES_LO: hrdata <= {24'h000000, res_lo};
          ADCC_OFS_CTL0: hrdata <= {24'h000000, 2'b00, ctl0[5:0]};
          ADCC_OFS_CTL1: hrdata <= {24'h000000, 2'b00, ctl1[5:0]};
          ADCC_OFS_CTL2: hrdata <= {24'h000000, ctl2[7], 1'b0, ctl2[5:0]};
          ADCC_OFS_STAT: hrdata <= {30'h0, state != ADCC_IDLE,
                                    conv_done_flag};
          default: hrdata <= 32'h00000000; // unmapped reads zero
        endcase
      end
    end
  end

  // configuration registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctl1 <= ADCC_CTL_RST;
      ctl2 <= ADCC_CTL_RST;
    end
    else if (dph.act && dph.wr)
    begin
      if (dph.addr == ADCC_OFS_CTL1)
        ctl1 <= {2'b00, hwdata[5:0]};
      if (dph.addr == ADCC_OFS_CTL2)
        ctl2 <= {hwdata[7], 1'b0, hwdata[5:0]};
    end
  end

  // control zero: go is set by software or trigger, cleared by
  // completion, by software, or by switching the converter off
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctl0 <= ADCC_CTL_RST;
    end
    else
    begin
      if (wr_ctl0)
      begin
        ctl0[5:ADCC_CHS_LSB] <= hwdata[5:ADCC_CHS_LSB];
        ctl0[ADCC_ON_BIT] <= hwdata[ADCC_ON_BIT];
        // go is honoured only when the converter was already on
        ctl0[ADCC_GO_BIT] <= hwdata[ADCC_GO_BIT] && hwdata[ADCC_ON_BIT]
          && conv_on;
      end
      else if (conv_done)
        ctl0[ADCC_GO_BIT] <= 1'b0;
      // a trigger wins over any clear in the same cycle except a write switching the converter off
      if (trig_hit && conv_on && (!wr_ctl0 || hwdata[ADCC_ON_BIT]))
        ctl0[ADCC_GO_BIT] <= 1'b1;
      ctl0[7:6] <= 2'b00;
    end
  end

  // the compare unit timer is reset whether or not the converter is on
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      timer_reset <= 1'b0;
    else
      timer_reset <= trig_hit;
  end

  // done flag: hardware set beats a write-one clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      conv_done_flag <= 1'b0;
    else if (conv_done)
      conv_done_flag <= 1'b1;
    else if (dph.act && dph.wr && dph.addr == ADCC_OFS_STAT
             && hwdata[ADCC_DONE_BIT])
      conv_done_flag <= 1'b0;
  end

  // result registers carry no reset, so any reset leaves them as they were;
  // an abort never reaches the load, keeping the last value
  always_ff @(posedge hclk)
  begin
    if (conv_done)
    begin
      if (ctl2[ADCC_FMT_BIT])
      begin
        res_hi <= {6'b000000, sar[9:8]};
        res_lo <= sar[7:0];
      end
      else
      begin
        res_hi <= sar[9:2];
        res_lo <= {sar[1:0], 6'b000000};
      end
    end
    else if (dph.act && dph.wr)
    begin
      if (dph.addr == ADCC_OFS_RES_HI)
        res_hi <= hwdata[7:0];
      if (dph.addr == ADCC_OFS_RES_LO)
        res_lo <= hwdata[7:0];
    end
  end

  // ----------------------------------------
  // bit clock
  // ----------------------------------------
  // a select change mid-count to a smaller divider ends the period early; a change to a larger one stretches it
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pre <= '0;
    else if (div == 7'd0 || {1'b0, pre} >= div - 7'd1)
      pre <= '0;
    else
      pre <= pre + 6'd1;
  end

  always_comb
  begin
    if (div == 7'd0)
      bit_tick = rc_tick;
    else
      bit_tick = {1'b0, pre} >= div - 7'd1;
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  // channel and direction bits never enter this process
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state <= ADCC_IDLE;
      cnt <= '0;
    end
    else
    begin
      case (state)
        ADCC_IDLE:
        begin
          cnt <= '0;
          if (go)
            state <= acq_len(ctl2[ADCC_ACQ_LSB +: 3]) == 5'd0 ?
              ADCC_CONV : ADCC_ACQ;
        end
        ADCC_ACQ:
        begin
          if (!go)
          begin
            state <= ADCC_WAIT;
            cnt <= '0;
          end
          else if (bit_tick)
          begin
            if (cnt + 5'd1 >= acq_len(ctl2[ADCC_ACQ_LSB +: 3]))
            begin
              state <= ADCC_CONV;
              cnt <= '0;
            end
            else
              cnt <= cnt + 5'd1;
          end
        end
        ADCC_CONV:
        begin
          if (!go)
          begin
            state <= ADCC_WAIT;
            cnt <= '0;
          end
          else if (conv_done)
          begin
            state <= ADCC_IDLE;
            cnt <= '0;
          end
          else if (bit_tick)
            cnt <= cnt + 5'd1;
        end
        ADCC_WAIT:
        begin
          if (bit_tick)
          begin
            if (cnt == ADCC_ABORT_TADS - 5'd1)
            begin
              state <= ADCC_IDLE;
              cnt <= '0;
            end
            else
              cnt <= cnt + 5'd1;
          end
        end
        default:
        begin
          state <= ADCC_IDLE;
          cnt <= '0;
        end
      endcase
    end
  end

  // successive approximation: period 0 samples, 1..10 decide bits
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      sar <= 10'h200;
    else if (state != ADCC_CONV)
      sar <= 10'h200;
    else if (bit_tick && cnt >= 5'd1 && cnt <= 5'd10)
    begin
      for (int b = 0; b < ADCC_RES_W; b++)
      begin
        if (5'(10 - b) == cnt)
        begin
          if (!comp_in)
            sar[b] <= 1'b0;
          if (b > 0)
            sar[(b > 0) ? b - 1 : 0] <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // analog side and port read
  // ----------------------------------------
  assign nana = ctl1[3:0] == 4'h0 ? 5'd16 : 5'd15 - {1'b0, ctl1[3:0]};
  always_comb
  begin
    for (int i = 0; i < 16; i++)
      amask[i] = 5'(i) < nana;
  end

  // hold capacitor opens on entry to the conversion, closes at its end;
  // pins driven as outputs are sampled like any other level
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ana <= '0;
      port_read_value <= '0;
    end
    else
    begin
      ana.conv_on <= conv_on;
      ana.hold_connected <= !((state == ADCC_IDLE && go
        && acq_len(ctl2[ADCC_ACQ_LSB +: 3]) == 5'd0)
        || (state == ADCC_ACQ && go && bit_tick
        && cnt + 5'd1 >= acq_len(ctl2[ADCC_ACQ_LSB +: 3]))
        || (state == ADCC_CONV && go && !conv_done));
      ana.channel_select <= ctl0[5:ADCC_CHS_LSB];
      ana.vref_cfg <= ctl1[5:4];
      ana.dac_code <= sar;
      port_read_value <= pin_level & ~amask;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic [4:0] chk_conv; // bit periods seen in conversion
  logic [4:0] chk_wait; // bit periods seen in abort wait
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      chk_conv <= '0;
      chk_wait <= '0;
    end
    else
    begin
      chk_conv <= state != ADCC_CONV ? 5'd0 : chk_conv + 5'(bit_tick);
      // restart on every stay outside the wait, so an abort taken during
      // acquisition counts from zero as well
      chk_wait <= state != ADCC_WAIT ? 5'd0 : chk_wait + 5'(bit_tick);
    end
  end

  property p_conv_len;
    conv_done |-> chk_conv == 5'd11;
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");

  property p_div2;
    (bit_tick && ctl2[2:0] == 3'h0) |=> !bit_tick ##1 (bit_tick || ctl2[2:0] != 3'h0);
  endproperty
  a_div2: assert property (p_div2) else $error("divide by two wrong");

  property p_done;
    conv_done |=> !go && conv_done_flag && state == ADCC_IDLE;
  endproperty
  a_done: assert property (p_done) else $error("completion effects missing");

  property p_abort;
    (state == ADCC_CONV && !go) |=> state == ADCC_WAIT;
  endproperty
  a_abort: assert property (p_abort) else $error("abort not taken");

  property p_keep;
    (state == ADCC_CONV && !go && !(dph.act && dph.wr)) |=> $stable(res_hi) && $stable(res_lo);
  endproperty
  a_keep: assert property (p_keep) else $error("abort changed result");

  property p_wait;
    $fell(state == ADCC_WAIT) |-> chk_wait == ADCC_ABORT_TADS;
  endproperty
  a_wait: assert property (p_wait) else $error("abort wait wrong");

  property p_trig;
    (trig_hit && conv_on && !wr_ctl0) |=> go ##0 timer_reset;
  endproperty
  a_trig: assert property (p_trig) else $error("trigger did not start");

  property p_trig_off;
    (trig_hit && !conv_on && !wr_ctl0) |=> !go && timer_reset;
  endproperty
  a_trig_off: assert property (p_trig_off) else $error("trigger not ignored");

  property p_hold;
    (state == ADCC_CONV && $past(state) == ADCC_CONV) |-> !ana.hold_connected;
  endproperty
  a_hold: assert property (p_hold) else $error("hold closed in conversion");

  property p_port;
    1'b1 |=> (port_read_value & $past(amask)) == 16'h0000;
  endproperty
  a_port: assert property (p_port) else $error("analog pin read nonzero");

endmodule

// >>> adcc_pkg.sv
// adcc_pkg: constants and types shared by the converter control block.
// assumes one 200 MHz clock and a 32-bit AHB-Lite register bus.
package adcc_pkg;

  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [7:0] ADCC_OFS_RES_HI = 8'h00; // result_high_byte
  localparam logic [7:0] ADCC_OFS_RES_LO = 8'h04; // result_low_byte
  localparam logic [7:0] ADCC_OFS_CTL0 = 8'h08; // converter_control_zero
  localparam logic [7:0] ADCC_OFS_CTL1 = 8'h0C; // converter_control_one
  localparam logic [7:0] ADCC_OFS_CTL2 = 8'h10; // converter_control_two
  localparam logic [7:0] ADCC_OFS_STAT = 8'h14; // done flag and busy

  // ----------------------------------------
  // reset values and field positions
  // ----------------------------------------
  localparam logic [7:0] ADCC_CTL_RST = 8'h00;
  localparam int ADCC_ON_BIT = 0; // converter_on
  localparam int ADCC_GO_BIT = 1; // go / done
  localparam int ADCC_CHS_LSB = 2; // channel_select, 4 bits
  localparam int ADCC_FMT_BIT = 7; // right justify when set
  localparam int ADCC_ACQ_LSB = 3; // acquisition_time_select, 3 bits
  localparam int ADCC_CLK_LSB = 0; // conv_clock_select, 3 bits
  localparam int ADCC_DONE_BIT = 0; // conv_done_flag, write one clears
  localparam int ADCC_BUSY_BIT = 1;

  // ----------------------------------------
  // sequencing figures, the two tad counts in conv_bit_period units
  // ----------------------------------------
  localparam logic [4:0] ADCC_CONV_TADS = 5'd12;
  localparam logic [4:0] ADCC_ABORT_TADS = 5'd2;
  localparam logic [3:0] ADCC_TRIG_MODE = 4'hB;
  localparam int ADCC_RES_W = 10;

  // sequencer states
  typedef enum logic [1:0] {
    ADCC_IDLE = 2'b00,
    ADCC_ACQ = 2'b01,
    ADCC_CONV = 2'b10,
    ADCC_WAIT = 2'b11
  } adcc_state_type;

  // captured address phase of one bus transfer
  typedef struct packed {
    logic act;
    logic wr;
    logic [7:0] addr;
  } adcc_bus_type;

  // analog front end controls
  typedef struct packed {
    logic conv_on;
    logic hold_connected;
    logic [3:0] channel_select;
    logic [1:0] vref_cfg;
    logic [ADCC_RES_W-1:0] dac_code;
  } adcc_ana_type;

endpackage

// >>> adcc_far_model.sv
// adcc_far_model: comparator, rc source and compare unit facing the block.
// assumes the bench sets the analog level and asks for triggers by fire.
module adcc_far_model #(
  parameter int RC_DIV = 6
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire adcc_pkg::adcc_ana_type ana,
  input wire logic [9:0] level,
  input wire logic fire,
  output logic comp_in,
  output logic rc_tick,
  output logic special_trigger
);
  import adcc_pkg::*;
  logic [9:0] held; // charge on the hold capacitor
  int rc_cnt; // rc oscillator phase

  // ---------
  // sampling
  // ---------
  // the capacitor follows the pin only while connected, so a level change
  // during conversion cannot leak into the result
  always_ff @(posedge hclk)
  begin
    if (ana.hold_connected)
    begin
      held <= level;
    end
  end
  // one means the held input is at or above the trial word
  assign comp_in = (held >= ana.dac_code);

  // ---------
  // rc source and compare unit
  // ---------
  // rc runs free; its phase is unrelated to conversion start
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rc_cnt <= 0;
      rc_tick <= 1'b0;
    end
    else
    begin
      rc_cnt <= (rc_cnt == RC_DIV - 1) ? 0 : rc_cnt + 1;
      rc_tick <= (rc_cnt == 0);
    end
  end
  // event pulse one cycle wide, launched a cycle after the request
  always_ff @(posedge hclk)
  begin
    special_trigger <= fire;
  end
endmodule

// >>> adcc_tb.sv
// adcc_tb: register level tests of the converter control block.
// assumes one slave on the bus, so hreadyout is fed back as hready.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import adcc_pkg::*;
  localparam int RC_DIV = 6;
  localparam int DIV_T[8] = '{2, 8, 32, RC_DIV, 4, 16, 64, RC_DIV};
  localparam int ACQ_T[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
  localparam logic [3:0] PC[3] = '{4'h0, 4'h5, 4'hF};
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, fire;
  logic comp_in, rc_tick, special_trigger, timer_reset, conv_done_flag;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] mode_f;
  logic [15:0] pin_level, port_read_value, e16;
  logic [9:0] lvl;
  logic [31:0] v;
  adcc_ana_type ana;
  int err_total, compares, cyc, ta, tt, t0, n;

  adcc_top adcc_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .comp_in(comp_in),
    .rc_tick(rc_tick), .special_trigger(special_trigger),
    .compare_unit_mode_field(mode_f), .pin_level(pin_level), .ana(ana),
    .timer_reset(timer_reset), .conv_done_flag(conv_done_flag),
    .port_read_value(port_read_value));
  adcc_far_model #(.RC_DIV(RC_DIV)) adcc_far_model_i (.hclk(hclk), .hresetn(hresetn),
    .ana(ana), .level(lvl), .fire(fire), .comp_in(comp_in), .rc_tick(rc_tick),
    .special_trigger(special_trigger));

  // ---------
  // clock, cycle count, report
  // ---------
  initial
  begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  always @(posedge hclk) cyc <= cyc + 1;
  task give_verdict;
    $display("counts: %0d compares, %0d mismatches", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task timed_out;
    err_total++;
    $display("wrong value wait limit expected end seen hang");
    give_verdict();
  endtask
  task chk_v(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // cycle counts carry a tolerance for prescaler phase at start
  task chk_t(input string nm, input int e, input int g, input int tol);
    compares++;
    if (g > e + tol || g < e - tol)
    begin
      err_total++;
      $display("wrong value %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  // ---------
  // bus master
  // ---------
  // hready and read data are taken at the rising edge, before it updates them
  task rdy(output logic [31:0] rd);
    int k;
    k = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
    begin
      k++;
      if (k > 50) timed_out();
      @(posedge hclk);
    end
    rd = hrdata;
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    logic [31:0] d;
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    rdy(d);
    htrans <= 2'b00;
    hwdata <= wd;
    rdy(rd);
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h0, d}, v);
  endtask
  task rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, v);
    chk_v(nm, e, v);
  endtask
  // sel 0 watches the hold switch, sel 1 the done flag
  task wait_for(input int sel, input logic lv);
    int k;
    k = 0;
    do
    begin
      @(negedge hclk);
      k++;
      if (k > 5000) timed_out();
    end
    while (((sel == 0) ? ana.hold_connected : conv_done_flag) !== lv);
  endtask
  // the pin level flips once the hold opens; the result must not see it
  task run_conv(input logic [7:0] c2, input logic [3:0] ch, output int a, output int t);
    int s;
    wr(ADCC_OFS_CTL2, c2);
    wr(ADCC_OFS_CTL0, {2'b00, ch, 2'b11});
    s = cyc;
    wait_for(0, 1'b0);
    a = cyc - s;
    @(posedge hclk);
    lvl <= ~lvl;
    wait_for(1, 1'b1);
    t = cyc - s;
  endtask
  task trig(input logic [3:0] m, input logic [7:0] c0, input logic tr_e, input logic go_e);
    int seen;
    wr(ADCC_OFS_CTL0, c0);
    mode_f <= m;
    @(posedge hclk);
    fire <= 1'b1;
    @(posedge hclk);
    fire <= 1'b0;
    seen = 0;
    repeat (6)
    begin
      @(negedge hclk);
      if (timer_reset === 1'b1) seen++;
    end
    chk_v("timer reset pulses", {31'h0, tr_e}, seen);
    if (go_e)
    begin
      wait_for(1, 1'b1);
      rdchk("trig result low", ADCC_OFS_RES_LO, 32'hA5);
      wr(ADCC_OFS_STAT, 8'h01);
    end
    else
      rdchk("no conversion", ADCC_OFS_STAT, 32'h0);
  endtask

  // ---------
  // test sequence
  // ---------
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    fire = 1'b0;
    mode_f = 4'h0;
    pin_level = 16'hFFFF;
    lvl = 10'h2A5;
    err_total = 0;
    compares = 0;
    cyc = 0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    rdchk("ctl0 reset", ADCC_OFS_CTL0, 32'h0);
    rdchk("ctl1 reset", ADCC_OFS_CTL1, 32'h0);
    rdchk("ctl2 reset", ADCC_OFS_CTL2, 32'h0);
    rdchk("status reset", ADCC_OFS_STAT, 32'h0);
    rdchk("unmapped", 8'h18, 32'h0);
    chk_v("hresp", 32'h0, {31'h0, hresp});
    wr(ADCC_OFS_CTL0, 8'h02);
    rdchk("go while off", ADCC_OFS_CTL0, 32'h0);
    wr(ADCC_OFS_CTL0, 8'h01);
    $display("test reset and enable done");
    // every clock code, a different channel each time, acquisition zero
    for (int c = 0; c < 8; c++)
    begin
      lvl <= 10'h2A5;
      run_conv({5'b10000, c[2:0]}, c[3:0], ta, tt);
      if (c == 0) t0 = tt;
      chk_t("conv time", 12 * (DIV_T[c] - 2), tt - t0, DIV_T[c] + 2);
      rdchk("result high", ADCC_OFS_RES_HI, 32'h02);
      rdchk("result low", ADCC_OFS_RES_LO, 32'hA5);
      rdchk("go cleared", ADCC_OFS_CTL0, {26'h0, c[3:0], 2'b01});
      rdchk("done set", ADCC_OFS_STAT, 32'h1);
      wr(ADCC_OFS_STAT, 8'h01);
    end
    $display("test clock select done");
    for (int a = 0; a < 8; a++)
    begin
      lvl <= 10'h2A5;
      run_conv({2'b00, a[2:0], 3'b100}, 4'h3, ta, tt);
      if (a == 0) t0 = ta;
      chk_t("acq time", ACQ_T[a] * 4, ta - t0, 3);
      wr(ADCC_OFS_STAT, 8'h01);
    end
    rdchk("left high", ADCC_OFS_RES_HI, 32'hA9);
    rdchk("left low", ADCC_OFS_RES_LO, 32'h40);
    $display("test acquisition done");
    wr(ADCC_OFS_RES_HI, 8'h55);
    wr(ADCC_OFS_RES_LO, 8'hAA);
    wr(ADCC_OFS_CTL2, 8'h86);
    wr(ADCC_OFS_CTL0, 8'h03);
    wait_for(0, 1'b0);
    repeat (40) @(posedge hclk);
    t0 = cyc;
    wr(ADCC_OFS_CTL0, 8'h01);
    n = 0;
    do
    begin
      bus(1'b0, ADCC_OFS_STAT, 32'h0, v);
      n++;
      if (n > 200) timed_out();
    end
    while (v[ADCC_BUSY_BIT] !== 1'b0);
    chk_t("abort wait", 2 * 64, cyc - t0, 64);
    chk_v("done after abort", 32'h0, {31'h0, conv_done_flag});
    rdchk("kept high", ADCC_OFS_RES_HI, 32'h55);
    rdchk("kept low", ADCC_OFS_RES_LO, 32'hAA);
    chk_v("hold back", 32'h1, {31'h0, ana.hold_connected});
    $display("test abort done");
    wr(ADCC_OFS_CTL2, 8'h80);
    lvl <= 10'h2A5;
    repeat (20) @(posedge hclk);
    trig(4'hB, 8'h00, 1'b1, 1'b0);
    trig(4'hA, 8'h01, 1'b0, 1'b0);
    trig(4'hB, 8'h01, 1'b1, 1'b1);
    $display("test trigger done");
    for (int i = 0; i < 3; i++)
    begin
      wr(ADCC_OFS_CTL1, {4'h0, PC[i]});
      repeat (2) @(negedge hclk);
      e16 = 16'hFFFF << ((PC[i] == 4'h0) ? 16 : 15 - PC[i]);
      chk_v("port read", {16'h0, e16}, {16'h0, port_read_value});
    end
    $display("test port read done");
    wr(ADCC_OFS_RES_HI, 8'h5A);
    wr(ADCC_OFS_RES_LO, 8'h3C);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    rdchk("high over reset", ADCC_OFS_RES_HI, 32'h5A);
    rdchk("low over reset", ADCC_OFS_RES_LO, 32'h3C);
    rdchk("ctl0 after reset", ADCC_OFS_CTL0, 32'h0);
    $display("test second reset done");
    give_verdict();
  end
endmodule
